// ===== inr_defines.svh
// Purpose: Constants of the noise reduction control block
// Assumes: Included by bare name, definitions only
// Notes:   Widths fixed at build time
`ifndef INR_DEFINES_SVH
`define INR_DEFINES_SVH

`define INR_COMP_W        8
`define INR_DATA_W        24
`define INR_COMP_CNT      3
`define INR_FIFO_DEPTH    16
`define INR_STR_W         3
`define INR_STR_DEFAULT   3'h1
`define INR_STR_MAX       3'h4
`define INR_CNT_W         13
`define INR_COLUMN_LIMIT  13'h0780
`define INR_ROW_LIMIT     13'h0438
`define INR_CTRL_EN       0
`define INR_CTRL_UPD      1
`define INR_WORD_W        32
`define INR_FILT_SHIFT    3

`endif

// ===== inr_pkg.sv
// Purpose: Types of the noise reduction control block
// Assumes: inr_defines.svh holds the numbers
// Notes:   Video word packed Cb/U, Cr/V, Y from the top down
`include "inr_defines.svh"

package inr_pkg;

  typedef struct packed {
    logic [`INR_DATA_W-1:0] data;
    logic                   hblank;
    logic                   vblank;
    logic                   active;
  } inr_vid_t;

  typedef enum logic [1:0] {
    INR_MODE_REG   = 2'b00,
    INR_MODE_PORT  = 2'b01,
    INR_MODE_CONST = 2'b10
  } inr_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_RESYNC = 2'b01,
    ST_RUN    = 2'b10
  } inr_state_t;

endpackage

// ===== inr_fifo.sv
// Purpose: Stream FIFO with valid/ready on both sides
// Assumes: Single clock, clock enable and synchronous clear
// Notes:   Head word read combinationally from the array
`timescale 1ns/1ps
`default_nettype none

module inr_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             sclr,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = ce && !sclr && in_valid && !full;
  assign pop       = ce && !sclr && out_ready && !empty;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (sclr) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
    end else begin
      if (push) begin
        wr_ptr_next = wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_next = rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ===== inr_ctrl.sv
// Purpose: Control side of a video smoothing filter pulling each pixel toward the previous one
// Assumes: Video stream and controls synchronous to sys_clk
// Notes:   Build option chosen by MODE; FIFO ahead of the output
`timescale 1ns/1ps
`default_nettype none

module inr_ctrl
  import inr_pkg::*;
#(
  parameter inr_mode_t MODE = INR_MODE_REG
) (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   sclr,
  input  wire logic                   ce,
  input  wire logic                   sw_reset,
  input  wire logic [1:0]             control_word,
  input  wire logic [`INR_STR_W-1:0]  strength_in,
  input  wire logic                   wr_en,
  input  wire logic [`INR_WORD_W-1:0] wr_data,
  output logic      [`INR_WORD_W-1:0] rd_data,
  output logic      [`INR_STR_W-1:0]  work_strength,
  output logic                        timing_locked,
  output logic                        col_overrun,
  output logic                        row_overrun,
  input  wire inr_vid_t               vid_in,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  output inr_vid_t                    vid_out,
  output logic                        out_valid,
  input  wire logic                   out_ready
);

  inr_state_t             state_reg;
  inr_state_t             state_next;
  logic [`INR_STR_W-1:0]  work_str_reg;
  logic [`INR_STR_W-1:0]  work_str_next;
  logic [`INR_STR_W-1:0]  shadow_str_reg;
  logic [`INR_STR_W-1:0]  shadow_str_next;
  logic                   vb_prev_reg;
  logic                   vb_prev_next;
  logic                   hb_prev_reg;
  logic                   hb_prev_next;
  logic [`INR_DATA_W-1:0] prev_pix_reg;
  logic [`INR_DATA_W-1:0] prev_pix_next;
  logic                   prev_act_reg;
  logic                   prev_act_next;
  logic [`INR_CNT_W-1:0]  col_cnt_reg;
  logic [`INR_CNT_W-1:0]  col_cnt_next;
  logic [`INR_CNT_W-1:0]  row_cnt_reg;
  logic [`INR_CNT_W-1:0]  row_cnt_next;
  logic                   col_ovf_reg;
  logic                   col_ovf_next;
  logic                   row_ovf_reg;
  logic                   row_ovf_next;
  inr_vid_t               out_reg;
  inr_vid_t               out_next;
  logic                   out_vld_reg;
  logic                   out_vld_next;

  logic                   en;
  logic                   upd;
  logic                   sw_rst;
  logic [`INR_STR_W-1:0]  str_src;
  logic [`INR_STR_W-1:0]  str_clamp;
  logic                   pass;
  logic                   fifo_in_ready;
  logic                   fifo_push;
  logic                   accept;
  logic                   vb_rise;
  logic                   hb_rise;
  logic                   load;
  inr_vid_t               filt;
  logic                   fifo_out_valid;
  inr_vid_t               fifo_out_data;
  logic                   pop;

  // Build-dependent control sources
  assign en      = (MODE == INR_MODE_CONST) ? 1'b1 :
                   control_word[`INR_CTRL_EN];
  assign upd     = control_word[`INR_CTRL_UPD];
  assign sw_rst  = (MODE == INR_MODE_CONST) ? 1'b0 : sw_reset;
  assign str_src = (MODE == INR_MODE_PORT) ? strength_in :
                   shadow_str_reg;
  assign str_clamp = (str_src > `INR_STR_MAX) ? `INR_STR_MAX :
                     str_src;

  // Stream acceptance; dropped input while not passing
  assign pass     = (state_reg == ST_RUN) && en && !sw_rst;
  assign accept   = ce && !sclr && in_valid &&
                    (fifo_in_ready || !pass);
  assign in_ready = fifo_in_ready || !pass;
  assign fifo_push = accept && pass;
  assign vb_rise  = accept && vid_in.vblank && !vb_prev_reg;
  assign hb_rise  = accept && vid_in.hblank && !hb_prev_reg;
  assign load     = vb_rise && en && upd && !sw_rst &&
                    (MODE != INR_MODE_CONST);

  // Control state
  always_comb begin
    state_next      = state_reg;
    work_str_next   = work_str_reg;
    shadow_str_next = shadow_str_reg;
    vb_prev_next    = vb_prev_reg;
    if (sclr) begin
      state_next      = ST_RESYNC;
      work_str_next   = `INR_STR_DEFAULT;
      shadow_str_next = `INR_STR_DEFAULT;
      vb_prev_next    = 1'b0;
    end else if (ce) begin
      if (accept) begin
        vb_prev_next = vid_in.vblank;
      end
      if (sw_rst) begin
        state_next      = ST_HOLD;
        work_str_next   = `INR_STR_DEFAULT;
        shadow_str_next = `INR_STR_DEFAULT;
      end else begin
        case (state_reg)
          ST_HOLD: begin
            state_next = ST_RESYNC;
          end
          ST_RESYNC: begin
            if (vb_rise) begin
              state_next = ST_RUN;
            end
          end
          ST_RUN: begin
            state_next = ST_RUN;
          end
          default: begin
            state_next = ST_RESYNC;
          end
        endcase
        if (wr_en && (MODE == INR_MODE_REG)) begin
          shadow_str_next = wr_data[`INR_STR_W-1:0];
        end
        if (load) begin
          work_str_next = str_clamp;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_RESYNC;
      work_str_reg   <= `INR_STR_DEFAULT;
      shadow_str_reg <= `INR_STR_DEFAULT;
      vb_prev_reg    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      work_str_reg   <= work_str_next;
      shadow_str_reg <= shadow_str_next;
      vb_prev_reg    <= vb_prev_next;
    end
  end

  // Per-component smoothing toward the previous pixel
  genvar gi;
  generate
    for (gi = 0; gi < `INR_COMP_CNT; gi++) begin : g_comp
      logic signed [`INR_COMP_W+4:0] cur;
      logic signed [`INR_COMP_W+4:0] prv;
      logic signed [`INR_COMP_W+4:0] dif;
      logic signed [`INR_COMP_W+4:0] adj;
      logic signed [`INR_COMP_W+4:0] res;
      assign cur = $signed({5'h00,
                   vid_in.data[gi*`INR_COMP_W +: `INR_COMP_W]});
      assign prv = $signed({5'h00,
                   prev_pix_reg[gi*`INR_COMP_W +: `INR_COMP_W]});
      assign dif = cur - prv;
      assign adj = (`INR_COMP_W+5)'((dif *
                   $signed({1'b0, work_str_reg})) >>> `INR_FILT_SHIFT);
      assign res = (prev_act_reg && vid_in.active) ? cur - adj : cur;
      assign filt.data[gi*`INR_COMP_W +: `INR_COMP_W] =
             res[`INR_COMP_W-1:0];
    end
  endgenerate

  assign filt.hblank = vid_in.hblank;
  assign filt.vblank = vid_in.vblank;
  assign filt.active = vid_in.active;

  // Previous pixel and geometry counters
  always_comb begin
    prev_pix_next = prev_pix_reg;
    prev_act_next = prev_act_reg;
    hb_prev_next  = hb_prev_reg;
    col_cnt_next  = col_cnt_reg;
    row_cnt_next  = row_cnt_reg;
    col_ovf_next  = col_ovf_reg;
    row_ovf_next  = row_ovf_reg;
    if (sclr || (ce && sw_rst)) begin
      prev_pix_next = '0;
      prev_act_next = 1'b0;
      hb_prev_next  = 1'b0;
      col_cnt_next  = '0;
      row_cnt_next  = '0;
      col_ovf_next  = 1'b0;
      row_ovf_next  = 1'b0;
    end else if (accept) begin
      prev_pix_next = vid_in.data;
      prev_act_next = vid_in.active;
      hb_prev_next  = vid_in.hblank;
      if (vid_in.hblank) begin
        col_cnt_next = '0;
      end else if (vid_in.active) begin
        if (col_cnt_reg == `INR_COLUMN_LIMIT) begin
          col_ovf_next = 1'b1;
        end else begin
          col_cnt_next = col_cnt_reg + 1'b1;
        end
      end
      if (vid_in.vblank) begin
        row_cnt_next = '0;
      end else if (hb_rise) begin
        if (row_cnt_reg == `INR_ROW_LIMIT) begin
          row_ovf_next = 1'b1;
        end else begin
          row_cnt_next = row_cnt_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_pix_reg <= '0;
      prev_act_reg <= 1'b0;
      hb_prev_reg  <= 1'b0;
      col_cnt_reg  <= '0;
      row_cnt_reg  <= '0;
      col_ovf_reg  <= 1'b0;
      row_ovf_reg  <= 1'b0;
    end else begin
      prev_pix_reg <= prev_pix_next;
      prev_act_reg <= prev_act_next;
      hb_prev_reg  <= hb_prev_next;
      col_cnt_reg  <= col_cnt_next;
      row_cnt_reg  <= row_cnt_next;
      col_ovf_reg  <= col_ovf_next;
      row_ovf_reg  <= row_ovf_next;
    end
  end

  inr_fifo #(
    .WIDTH ($bits(inr_vid_t)),
    .DEPTH (`INR_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .sclr      (sclr || (ce && sw_rst)),
    .ce        (ce),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (filt),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // Output register stage
  assign pop = ce && !sclr && !sw_rst && (!out_vld_reg || out_ready);

  always_comb begin
    out_next     = out_reg;
    out_vld_next = out_vld_reg;
    if (sclr || (ce && sw_rst)) begin
      out_next     = '0;
      out_vld_next = 1'b0;
    end else if (ce) begin
      if (pop && fifo_out_valid) begin
        out_next     = fifo_out_data;
        out_vld_next = 1'b1;
      end else if (out_ready) begin
        out_vld_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_reg     <= '0;
      out_vld_reg <= 1'b0;
    end else begin
      out_reg     <= out_next;
      out_vld_reg <= out_vld_next;
    end
  end

  assign vid_out       = out_reg;
  assign out_valid     = out_vld_reg;
  assign rd_data       = {{(`INR_WORD_W-`INR_STR_W){1'b0}},
                          shadow_str_reg};
  assign work_strength = work_str_reg;
  assign timing_locked = (state_reg == ST_RUN);
  assign col_overrun   = col_ovf_reg;
  assign row_overrun   = row_ovf_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_release;
    state_reg == ST_HOLD && ce && !sclr && !sw_rst;
  endsequence

  sequence s_load_req;
    vb_rise && en && upd && !sw_rst && !sclr;
  endsequence

  a_strength_range: assert property (work_str_reg <= `INR_STR_MAX)
    else $error("working strength above four");

  a_load_at_edge: assert property (
    !sclr && !$past(sclr) && $changed(work_str_reg)
      |-> $past(load) || $past(sw_rst))
    else $error("strength changed away from vblank edge");

  a_hold_no_upd: assert property (
    ce && !sclr && !sw_rst && !upd |=> $stable(work_str_reg))
    else $error("strength changed with update off");

  a_disabled_noload: assert property (
    ce && !sclr && !sw_rst && !en |=> $stable(work_str_reg))
    else $error("strength changed while disabled");

  a_copy_value: assert property (
    s_load_req and (MODE != INR_MODE_CONST)
      |=> work_str_reg == $past(str_clamp))
    else $error("wrong strength copied at vblank edge");

  a_const_fixed: assert property (
    MODE == INR_MODE_CONST |-> work_str_reg == `INR_STR_DEFAULT)
    else $error("constant build strength moved");

  a_resync_order: assert property (
    s_release |=> state_reg == ST_RESYNC ##0 !timing_locked)
    else $error("release did not enter resync");

  a_reset_zero: assert property (
    ce && sw_rst && !sclr |=> out_vld_reg == 1'b0 && out_reg == '0
      && work_str_reg == `INR_STR_DEFAULT)
    else $error("soft reset left outputs or strength");

  a_disable_block: assert property (!en |-> !fifo_push)
    else $error("video pushed while disabled");

  a_ce_freeze: assert property (
    !ce && !sclr |=> $stable(out_reg) && $stable(out_vld_reg)
      && $stable(state_reg))
    else $error("state moved with clock enable low");

endmodule

`default_nettype wire

// ===== inr_sink_model.sv
// Purpose: Downstream video sink beside the noise reduction block
// Assumes: Shares sys_clk and ce with the block
// Notes:   Stall input holds ready low to back up the stream
`timescale 1ns/1ps
`default_nettype none

module inr_sink_model
  import inr_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     resetn,
  input  wire logic     ce,
  input  wire logic     stall,
  input  wire inr_vid_t vid_out,
  input  wire logic     out_valid,
  output logic          out_ready,
  output logic [15:0]   got_cnt,
  output logic [23:0]   got_data
);
  assign out_ready = !stall;

  // Counts and keeps each word handed over
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      got_cnt  <= 16'h0000;
      got_data <= 24'h000000;
    end else if (ce && out_valid && out_ready) begin
      got_cnt  <= got_cnt + 16'h0001;
      got_data <= vid_out.data;
    end
  end
endmodule

`default_nettype wire

// ===== inr_ctrl_bench.sv
// Purpose: Self-checking bench of the noise reduction control block
// Assumes: Register, port and constant builds share one stream
// Notes:   Strength 0 used where pixel values are compared
`timescale 1ns/1ps
`default_nettype none

module inr_ctrl_bench;
  import inr_pkg::*;
  logic        sys_clk, resetn, sclr, ce, sw_reset, wr_en, in_valid;
  logic        stall, timing_locked, col_overrun, row_overrun;
  logic        in_ready, out_valid, out_ready, lock_c;
  logic [1:0]  control_word;
  logic [2:0]  strength_in, work_strength, work_p, work_c;
  logic [31:0] wr_data, rd_data;
  logic [15:0] got_cnt, base;
  logic [23:0] got_data;
  inr_vid_t    vid_in, vid_out;
  int          num_errors, total_checks, cycles, n;

  inr_ctrl inr_ctrl_i (.*);
  inr_ctrl #(.MODE(INR_MODE_PORT)) inr_ctrl_p_i (.*, .rd_data(),
    .work_strength(work_p), .timing_locked(), .col_overrun(),
    .row_overrun(), .in_ready(), .vid_out(), .out_valid());
  inr_ctrl #(.MODE(INR_MODE_CONST)) inr_ctrl_c_i (.*, .rd_data(),
    .work_strength(work_c), .timing_locked(lock_c), .col_overrun(),
    .row_overrun(), .in_ready(), .vid_out(), .out_valid());
  inr_sink_model inr_sink_model_i (.sys_clk(sys_clk), .resetn(resetn),
    .ce(ce), .stall(stall), .vid_out(vid_out), .out_valid(out_valid),
    .out_ready(out_ready), .got_cnt(got_cnt), .got_data(got_data));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 9000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Holds the sample until an edge with in_ready high takes it
  task automatic push(input logic vb, input logic act,
                      input logic [23:0] d);
    vid_in = {d, 1'b0, vb, act};
    in_valid = 1'b1;
    n = 0;
    while (!in_ready && n < 100) begin
      tick(1);
      n++;
    end
    tick(1);
  endtask

  task automatic wr(input logic [31:0] v);
    wr_en = 1'b1;
    wr_data = v;
    tick(1);
    wr_en = 1'b0;
    tick(1);
  endtask

  // One vblank rise between two inactive samples (active low)
  task automatic vrise();
    push(1'b0, 1'b0, 24'h000000);
    push(1'b1, 1'b0, 24'h000000);
    push(1'b0, 1'b0, 24'h000000);
    in_valid = 1'b0;
    tick(2);
  endtask

  initial begin
    resetn = 1'b0;
    sclr = 1'b0;
    ce = 1'b1;
    sw_reset = 1'b0;
    control_word = 2'b01;
    strength_in = 3'h4;
    wr_en = 1'b0;
    wr_data = 32'h0;
    in_valid = 1'b0;
    vid_in = '0;
    stall = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    check(work_strength, 32'h1);
    check(rd_data, 32'h1);
    check(out_valid, 32'h0);
    vrise();
    check(timing_locked, 32'h1);
    wr(32'h0000_0003);
    check(rd_data, 32'h3);
    check(work_strength, 32'h1);
    vrise();
    check(work_strength, 32'h1);
    check(work_p, 32'h1);
    control_word = 2'b10;
    vrise();
    check(work_strength, 32'h1);
    control_word = 2'b11;
    vrise();
    check(work_strength, 32'h3);
    check(work_p, 32'h4);
    check(work_c, 32'h1);
    control_word = 2'b01;
    wr(32'hffff_fff8);
    check(rd_data, 32'h0);
    check(work_strength, 32'h3);
    control_word = 2'b11;
    vrise();
    control_word = 2'b01;
    check(work_strength, 32'h0);
    base = got_cnt;
    push(1'b0, 1'b1, 24'h123456);
    push(1'b0, 1'b1, 24'habcdef);
    in_valid = 1'b0;
    tick(6);
    check(got_data, 32'habcdef);
    check(got_cnt - base, 32'h2);
    control_word = 2'b00;
    base = got_cnt;
    push(1'b0, 1'b1, 24'h555555);
    in_valid = 1'b0;
    tick(6);
    check(got_cnt - base, 32'h0);
    vid_in = {24'h000000, 1'b0, 1'b0, 1'b1};
    in_valid = 1'b1;
    tick(1917);
    check(col_overrun, 32'h0);
    tick(1);
    check(col_overrun, 32'h1);
    repeat (1080) begin
      vid_in = {24'h000000, 1'b1, 1'b0, 1'b0};
      tick(1);
      vid_in = {24'h000000, 1'b0, 1'b0, 1'b0};
      tick(1);
    end
    check(row_overrun, 32'h0);
    vid_in = {24'h000000, 1'b1, 1'b0, 1'b0};
    tick(1);
    check(row_overrun, 32'h1);
    in_valid = 1'b0;
    vid_in = '0;
    control_word = 2'b01;
    ce = 1'b0;
    wr(32'h0000_0004);
    check(rd_data, 32'h0);
    ce = 1'b1;
    stall = 1'b1;
    base = got_cnt;
    n = 0;
    vid_in = {24'h00aa55, 1'b0, 1'b0, 1'b1};
    in_valid = 1'b1;
    repeat (24) begin
      if (in_ready === 1'b1)
        n++;
      tick(1);
    end
    in_valid = 1'b0;
    check(n, 32'd17);
    check(in_ready, 32'h0);
    stall = 1'b0;
    tick(30);
    check(got_cnt - base, 32'd17);
    check(in_ready, 32'h1);
    sw_reset = 1'b1;
    tick(2);
    check(work_strength, 32'h1);
    check(rd_data, 32'h1);
    check(vid_out, 32'h0);
    check(timing_locked, 32'h0);
    check(lock_c, 32'h1);
    check(col_overrun, 32'h0);
    check(row_overrun, 32'h0);
    sw_reset = 1'b0;
    tick(1);
    vrise();
    check(timing_locked, 32'h1);
    ce = 1'b0;
    sclr = 1'b1;
    tick(2);
    check(timing_locked, 32'h0);
    check(lock_c, 32'h0);
    sclr = 1'b0;
    ce = 1'b1;
    tick(2);
    results();
  end
endmodule

`default_nettype wire
